// File: rtl/ffi_top.sv
// Register access over APB was decided locally.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Each enable field reads 0h when disabled and 2h when enabled.
// - Writing 1h to a field disables it, 3h enables it.
// - Enable register at index 0Ch, reset AAh, all fields enabled.
// - Bus timeout interrupt has its own enable field, enabled at reset.
// - Bad string configuration interrupt has an enable field, enabled.
// - String fault enable lives in bits 1-0, enabled at reset.
// - A flag reads 0 with no fault, 1 once a fault is latched.
// - Writing one to flag and its ack together clears flag and pin; for overvolt low only the flag.
// - Supply flags at index 0Eh, eight flag/ack pairs from bit 15.
// - Converter flags at index 10h, eight flag/ack pairs from bit 15.
// - A configuration check error sets bit 15 of supply flags.
// - A missing converter sync sets bit 13 of supply flags.
// - Clearing overvolt low clears only its flag, not the pin.

module ffi_top (
	input wire logic clock,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ffi_pkg::ADDR_W-1:0] paddr,
	input wire logic [ffi_pkg::DATA_W-1:0] pwdata,
	output var logic [ffi_pkg::DATA_W-1:0] prdata,
	output var logic pready,
	output var logic pslverr,
	input wire logic config_check_err_det,
	input wire logic sync_missing_det,
	input wire logic pump_fault_det,
	input wire logic pump_cap_missing_det,
	input wire logic input_overcurrent_det,
	input wire logic supply_undervolt_det,
	input wire logic input_overvolt_det,
	input wire logic input_undervolt_det,
	input wire logic thermal_trip_det,
	input wire logic current_set_short_det,
	input wire logic string_res_missing_det,
	input wire logic mode_res_missing_det,
	input wire logic freq_res_missing_det,
	input wire logic converter_overcurrent_det,
	input wire logic converter_overvolt_high_det,
	input wire logic converter_overvolt_low_det,
	input wire logic string_fault_det,
	input wire logic bad_string_cfg_det,
	input wire logic bus_timeout_det,
	output var logic irq
);
	import ffi_pkg::*;

	// ************************************************************
	// Reset release
	// ************************************************************
	logic rst_s1_q;
	logic rst_n;

	// Reset asserts at once and releases two edges later.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rst_s1_q <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n <= rst_s1_q;
		end
	end

	// ************************************************************
	// Bus decode
	// ************************************************************
	// Answer, flag, event and mask state, then the decode wires.
	logic pready_q;
	logic pslverr_q;
	logic [DATA_W-1:0] prdata_q;
	logic irq_q;
	logic [NFAULT-1:0] flags_q;
	logic [NEVT-1:0] events_q;
	logic [NEVT-1:0] mask_q;
	wire logic access_ph;
	wire logic done;
	wire logic capture;
	wire logic sel_irq_en;
	wire logic sel_sup;
	wire logic sel_conv;
	wire logic sel_evt;
	wire logic sel_mask;
	wire logic hit;
	wire logic wr_irq_en;
	wire logic wr_sup;
	wire logic wr_conv;
	wire logic wr_mask;
	wire logic rd_evt_done;

	// One wait state: data is captured, then pready shows it.
	assign access_ph = psel & penable;
	assign capture = access_ph & ~pready_q;
	assign done = access_ph & pready_q;
	assign sel_irq_en = paddr == ADDR_IRQ_EN;
	assign sel_sup = paddr == ADDR_SUPPLY;
	assign sel_conv = paddr == ADDR_CONV;
	assign sel_evt = paddr == ADDR_EVENT;
	assign sel_mask = paddr == ADDR_MASK;
	assign hit = sel_irq_en | sel_sup | sel_conv | sel_evt | sel_mask;
	assign wr_irq_en = done & pwrite & sel_irq_en;
	assign wr_sup = done & pwrite & sel_sup;
	assign wr_conv = done & pwrite & sel_conv;
	assign wr_mask = done & pwrite & sel_mask;
	assign rd_evt_done = done & ~pwrite & sel_evt;

	// ************************************************************
	// Interrupt enable fields
	// ************************************************************
	// Field enables and their read codes, two bits per field.
	wire logic [NFIELD-1:0] fld_en;
	wire logic [2*NFIELD-1:0] fld_word;

	// Field j sits at bits 2j+1..2j of the enable register.
	for (genvar j = 0; j < NFIELD; j++) begin : g_field
		ffi_enable_field u_field (
			.clock(clock),
			.rst_n(rst_n),
			.we(wr_irq_en),
			.code(pwdata[2*j +: 2]),
			.en(fld_en[j]),
			.rd_code(fld_word[2*j +: 2])
		);
	end

	// ************************************************************
	// Fault flags and pin events
	// ************************************************************
	// Per-fault acks, next states and the packed read words.
	wire logic [NEVT-1:0] det_all;
	wire logic [NFAULT-1:0] ack;
	wire logic [NFAULT-1:0] flags_d;
	wire logic [NEVT-1:0] pin_ack;
	wire logic [NEVT-1:0] rd_clr;
	wire logic [NEVT-1:0] events_d;
	wire logic [NEVT-1:0] evt_en;
	wire logic [2*NFAULT-1:0] flag_word;
	wire logic irq_d;

	// Detector order matches the flag order from the top bit down.
	assign det_all = {bus_timeout_det, bad_string_cfg_det,
		string_fault_det,
		thermal_trip_det, current_set_short_det,
		string_res_missing_det, mode_res_missing_det,
		freq_res_missing_det, converter_overcurrent_det,
		converter_overvolt_high_det, converter_overvolt_low_det,
		config_check_err_det, sync_missing_det,
		pump_fault_det, pump_cap_missing_det,
		input_overcurrent_det, supply_undervolt_det,
		input_overvolt_det, input_undervolt_det};

	// A detector that is high keeps its flag set, so set beats clear.
	for (genvar i = 0; i < NFAULT; i++) begin : g_fault
		localparam int unsigned P = i % 8;
		assign ack[i] = ((i < 8) ? wr_sup : wr_conv)
			& pwdata[2*P+1] & pwdata[2*P];
		assign flags_d[i] = det_all[i] | (flags_q[i] & ~ack[i]);
		assign pin_ack[i] = (i == EVT_OVL) ? 1'b0 : ack[i];
		assign flag_word[2*i+1] = flags_q[i];
		assign flag_word[2*i] = 1'b0;
	end
	assign pin_ack[NEVT-1:NFAULT] = 3'h0;

	// Read clear drops only what the read returned; later events stay.
	assign rd_clr = rd_evt_done ? prdata_q[NEVT-1:0] : RST_EVENT;
	assign events_d = det_all | (events_q & ~rd_clr & ~pin_ack);

	// String level events pass only with their own enable field.
	assign evt_en = {fld_en[FLD_TIMEOUT], fld_en[FLD_BADCFG],
		fld_en[FLD_STRING], 16'hffff};
	assign irq_d = fld_en[FLD_GLOBAL]
		& (|(events_q & mask_q & evt_en));

	// Flags, events and the interrupt pin.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			flags_q <= RST_FLAGS;
			events_q <= RST_EVENT;
			irq_q <= 1'b0;
		end else begin
			flags_q <= flags_d;
			events_q <= events_d;
			irq_q <= irq_d;
		end
	end

	// Software mask; writes land at the completing edge only.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			mask_q <= RST_MASK;
		end else if (wr_mask) begin
			mask_q <= pwdata[NEVT-1:0];
		end
	end

	// ************************************************************
	// Read data and answer
	// ************************************************************
	wire logic [DATA_W-1:0] rd_word;

	// Unmapped and reserved bits read as zero.
	assign rd_word = sel_irq_en ? {24'h0, fld_word} :
		sel_sup ? {16'h0, flag_word[15:0]} :
		sel_conv ? {16'h0, flag_word[31:16]} :
		sel_evt ? {13'h0, events_q} :
		sel_mask ? {13'h0, mask_q} : 32'h0;

	// Answer registers; read data is taken in the first access cycle.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0;
		end else begin
			pready_q <= capture;
			pslverr_q <= capture & ~hit;
			prdata_q <= (capture & ~pwrite) ? rd_word : 32'h0;
		end
	end

	// Every output is a flop, so nothing combinational leaves the block.
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign irq = irq_q;

	// ************************************************************
	// Checks
	// ************************************************************
	// All checks share the one clock and sleep while reset holds.
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	a_enable_read: assert property (
		pready_q && sel_irq_en && !pwrite |->
		prdata_q[1:0] == {fld_en[FLD_STRING], 1'b0} &&
		prdata_q[7:6] == {fld_en[FLD_GLOBAL], 1'b0})
		else $error("enable read code wrong");
	a_enable_reset: assert property (
		$rose(rst_n) |-> fld_word == RST_IRQ_EN[7:0])
		else $error("enable register not at reset value");
	a_timeout_gate: assert property (
		events_q == 19'h40000 && !fld_en[FLD_TIMEOUT] |=> !irq_q)
		else $error("disabled timeout raised the pin");
	a_badcfg_gate: assert property (
		events_q == 19'h20000 && !fld_en[FLD_BADCFG] |=> !irq_q)
		else $error("disabled bad config raised the pin");
	a_string_field: assert property (
		fld_word[1:0] == (fld_en[FLD_STRING] ? 2'h2 : 2'h0))
		else $error("string enable not in bits 1-0");
	a_flag_latch: assert property (
		(flags_q & $past(det_all[NFAULT-1:0])) ==
		$past(det_all[NFAULT-1:0]))
		else $error("detected fault not latched");
	a_ack_clear: assert property (
		ack[SUP_SYNC] && !det_all[SUP_SYNC] |=>
		!flags_q[SUP_SYNC] && !events_q[SUP_SYNC])
		else $error("acknowledged fault not cleared");
	a_supply_read: assert property (
		pready_q && sel_sup && !pwrite |->
		prdata_q[15:0] == $past(flag_word[15:0]))
		else $error("supply flags read wrong");
	a_conv_read: assert property (
		pready_q && sel_conv && !pwrite |->
		prdata_q == {16'h0, $past(flag_word[31:16])})
		else $error("converter flags read wrong");
	a_crc_bit: assert property (
		config_check_err_det |=> flag_word[15] [*1] ##1 1)
		else $error("check error did not set bit 15");
	a_sync_bit: assert property (
		sync_missing_det |=> flag_word[13])
		else $error("missing sync did not set bit 13");
	a_ovl_pin_kept: assert property (
		ack[EVT_OVL] && events_q[EVT_OVL] && !rd_evt_done |=>
		events_q[EVT_OVL] && !flags_q[EVT_OVL] ||
		$past(det_all[EVT_OVL]))
		else $error("overvolt low clear touched the pin");
	a_irq_cause: assert property (
		irq_q |-> $past(fld_en[FLD_GLOBAL]) &&
		$past(|(events_q & mask_q & evt_en)))
		else $error("pin high without an enabled event");
	a_flag_hold: assert property (
		flags_q[SUP_CRC] && !ack[SUP_CRC] |=> flags_q[SUP_CRC])
		else $error("latched fault dropped without its ack");
	a_ovl_flag_clear: assert property (
		ack[EVT_OVL] && !det_all[EVT_OVL] |=> !flags_q[EVT_OVL])
		else $error("overvolt low flag not cleared by its ack");

	// Main scenarios that a run is expected to reach.
	c_irq_rise: cover property ($rose(irq_q));
	c_ack_done: cover property (ack[SUP_CRC] ##1 !flags_q[SUP_CRC]);
	c_evt_read: cover property (rd_evt_done && prdata_q != 32'h0);
	c_field_off: cover property ($fell(fld_en[FLD_GLOBAL]));
	c_gate_timeout: cover property (events_q[EVT_TIMEOUT] &&
		!fld_en[FLD_TIMEOUT]);

endmodule
`default_nettype wire

// File: rtl/ffi_pkg.sv
// ************************************************************
// Shared constants of the fault flag and interrupt registers.
// ************************************************************
package ffi_pkg;

	// Bus geometry.
	localparam int unsigned DATA_W = 32;
	localparam int unsigned ADDR_W = 12;

	// Register indices; the byte address is four times the index.
	localparam logic [7:0] IDX_IRQ_EN = 8'h0c;
	localparam logic [7:0] IDX_SUPPLY = 8'h0e;
	localparam logic [7:0] IDX_CONV = 8'h10;
	localparam logic [7:0] IDX_EVENT = 8'h20;
	localparam logic [7:0] IDX_MASK = 8'h21;
	localparam logic [11:0] ADDR_IRQ_EN = {2'h0, IDX_IRQ_EN, 2'h0};
	localparam logic [11:0] ADDR_SUPPLY = {2'h0, IDX_SUPPLY, 2'h0};
	localparam logic [11:0] ADDR_CONV = {2'h0, IDX_CONV, 2'h0};
	localparam logic [11:0] ADDR_EVENT = {2'h0, IDX_EVENT, 2'h0};
	localparam logic [11:0] ADDR_MASK = {2'h0, IDX_MASK, 2'h0};

	// Reset values.
	localparam logic [15:0] RST_IRQ_EN = 16'h00aa;
	localparam logic [15:0] RST_FLAGS = 16'h0000;
	localparam logic [18:0] RST_EVENT = 19'h00000;
	localparam logic [18:0] RST_MASK = 19'h7ffff;
	localparam logic RST_FIELD_EN = 1'b1;

	// Two-bit enable field codes.
	localparam logic [1:0] CODE_RD_OFF = 2'h0;
	localparam logic [1:0] CODE_RD_ON = 2'h2;
	localparam logic [1:0] CODE_WR_OFF = 2'h1;
	localparam logic [1:0] CODE_WR_ON = 2'h3;

	// Enable field positions, in field units of two bits.
	localparam int unsigned NFIELD = 4;
	localparam int unsigned FLD_STRING = 0;
	localparam int unsigned FLD_BADCFG = 1;
	localparam int unsigned FLD_TIMEOUT = 2;
	localparam int unsigned FLD_GLOBAL = 3;

	// Fault numbering: 0..7 supply, 8..15 converter, flag at bit 2n+1.
	localparam int unsigned NFAULT = 16;
	localparam int unsigned NEVT = 19;
	localparam int unsigned SUP_CRC = 7;
	localparam int unsigned SUP_SYNC = 6;
	localparam int unsigned EVT_OVL = 8;
	localparam int unsigned EVT_STRING = 16;
	localparam int unsigned EVT_BADCFG = 17;
	localparam int unsigned EVT_TIMEOUT = 18;

endpackage

// File: rtl/ffi_enable_field.sv
`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// One two-bit interrupt enable field.
// ************************************************************
module ffi_enable_field (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic we,
	input wire logic [1:0] code,
	output var logic en,
	output var logic [1:0] rd_code
);
	import ffi_pkg::*;

	logic en_q;
	logic en_d;

	// Only the two write codes move the state; other codes leave it.
	assign en_d = (we && code == CODE_WR_ON) ? 1'b1 :
		(we && code == CODE_WR_OFF) ? 1'b0 : en_q;

	// The enable state, on at reset.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			en_q <= RST_FIELD_EN;
		end else begin
			en_q <= en_d;
		end
	end

	// Read back is one of two codes only.
	assign en = en_q;
	assign rd_code = en_q ? CODE_RD_ON : CODE_RD_OFF;

	a_write_codes: assert property (@(posedge clock) disable iff (!rst_n)
		we && code[0] |=> en_q == code[1])
		else $error("enable field ignored a write code");
	a_other_codes: assert property (@(posedge clock) disable iff (!rst_n)
		we && !code[0] |=> $stable(en_q))
		else $error("enable field changed on a neutral code");

endmodule
`default_nettype wire

// File: verification/tb_ffi_top.sv
`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// Self-checking bench of the fault flag and interrupt registers.
// ************************************************************
module tb_ffi_top;
	import ffi_pkg::*;

	logic clock, nrst, psel, penable, pwrite, pready, pslverr, irq, err;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata, prdata, rd;
	logic [18:0] det;
	int num_errors, n_compared;

	// Detector bit n is fault n, in the same order as the event register.
	ffi_top u_ffi_top (
		.clock(clock), .nrst(nrst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr),
		.config_check_err_det(det[7]), .sync_missing_det(det[6]),
		.pump_fault_det(det[5]), .pump_cap_missing_det(det[4]),
		.input_overcurrent_det(det[3]), .supply_undervolt_det(det[2]),
		.input_overvolt_det(det[1]), .input_undervolt_det(det[0]),
		.thermal_trip_det(det[15]), .current_set_short_det(det[14]),
		.string_res_missing_det(det[13]), .mode_res_missing_det(det[12]),
		.freq_res_missing_det(det[11]),
		.converter_overcurrent_det(det[10]),
		.converter_overvolt_high_det(det[9]),
		.converter_overvolt_low_det(det[8]),
		.string_fault_det(det[16]), .bad_string_cfg_det(det[17]),
		.bus_timeout_det(det[18]), .irq(irq)
	);

	// ************************************************************
	// Shared tasks.
	// ************************************************************

	// Prints the counts and the verdict, then stops the run.
	task automatic print_verdict();
		$display("errors %0d, compared %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Compares with case equality so an unknown never passes.
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	// One APB transfer; the request holds until pready is sampled high.
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		int i;
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge clock);
			i++;
		end while (pready !== 1'b1 && i < 20);
		if (pready !== 1'b1) begin
			num_errors++;
			$display("mismatch at %0t: no ready", $time);
			print_verdict();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// One-cycle detector pulse, then time for flag and pin to settle.
	task automatic pulse(input int n);
		@(posedge clock);
		det[n] <= 1'b1;
		@(posedge clock);
		det[n] <= 1'b0;
		repeat (3) @(posedge clock);
	endtask

	task automatic settle();
		repeat (3) @(posedge clock);
	endtask

	// ************************************************************
	// Scenarios.
	// ************************************************************

	task automatic t_reset();
		check({31'h0, irq}, 32'h0);
		apb(1'b0, ADDR_IRQ_EN, 32'h0);
		check(rd, 32'h000000aa);
		check(32'(rd[1:0]), 32'h2);
		check(32'(rd[3:2]), 32'h2);
		check(32'(rd[5:4]), 32'h2);
		apb(1'b0, ADDR_SUPPLY, 32'h0);
		check(rd, 32'h0);
		apb(1'b0, ADDR_CONV, 32'h0);
		check(rd, 32'h0);
	endtask

	// Codes 1h and 3h switch a field, 0h and 2h leave it alone.
	task automatic t_codes();
		apb(1'b1, ADDR_IRQ_EN, 32'h55);
		apb(1'b0, ADDR_IRQ_EN, 32'h0);
		check(rd, 32'h0);
		apb(1'b1, ADDR_IRQ_EN, 32'haa);
		apb(1'b0, ADDR_IRQ_EN, 32'h0);
		check(rd, 32'h0);
		apb(1'b1, ADDR_IRQ_EN, 32'hff);
		apb(1'b1, ADDR_IRQ_EN, 32'h1d);
		apb(1'b0, ADDR_IRQ_EN, 32'h0);
		check(rd, 32'h88);
		apb(1'b1, ADDR_IRQ_EN, 32'hff);
	endtask

	// Every fault latches at bit 2m+1 and clears only with its ack.
	task automatic t_faults();
		logic [11:0] a;
		logic [31:0] b;
		for (int n = 0; n < 16; n++) begin
			a = (n < 8) ? ADDR_SUPPLY : ADDR_CONV;
			b = 32'h2 << (2 * (n % 8));
			pulse(n);
			apb(1'b0, a, 32'h0);
			check(rd, b);
			apb(1'b1, a, b);
			apb(1'b0, a, 32'h0);
			check(rd, b);
			apb(1'b1, a, b | (b >> 1));
			apb(1'b0, a, 32'h0);
			check(rd, 32'h0);
		end
		pulse(SUP_CRC);
		pulse(SUP_SYNC);
		apb(1'b0, ADDR_SUPPLY, 32'h0);
		check(rd, 32'h0000a000);
		apb(1'b1, ADDR_SUPPLY, 32'hf000);
		apb(1'b0, ADDR_EVENT, 32'h0);
		check(rd, 32'h100);
	endtask

	// Pin follows global enable, field enable, mask and clears.
	task automatic t_irq();
		settle();
		check({31'h0, irq}, 32'h0);
		pulse(3);
		check({31'h0, irq}, 32'h1);
		apb(1'b1, ADDR_SUPPLY, 32'h00c0);
		settle();
		check({31'h0, irq}, 32'h0);
		apb(1'b1, ADDR_IRQ_EN, 32'h40);
		pulse(EVT_STRING);
		check({31'h0, irq}, 32'h0);
		apb(1'b1, ADDR_IRQ_EN, 32'hc0);
		settle();
		check({31'h0, irq}, 32'h1);
		apb(1'b1, ADDR_IRQ_EN, 32'h01);
		settle();
		check({31'h0, irq}, 32'h0);
		apb(1'b0, ADDR_EVENT, 32'h0);
		check(rd, 32'h10000);
		apb(1'b1, ADDR_IRQ_EN, 32'h03);
		apb(1'b1, ADDR_MASK, 32'h0);
		pulse(0);
		check({31'h0, irq}, 32'h0);
		apb(1'b1, ADDR_MASK, 32'h7ffff);
		settle();
		check({31'h0, irq}, 32'h1);
		apb(1'b0, ADDR_EVENT, 32'h0);
		check(rd, 32'h1);
		settle();
		check({31'h0, irq}, 32'h0);
		apb(1'b1, ADDR_SUPPLY, 32'h3);
		pulse(EVT_OVL);
		apb(1'b1, ADDR_CONV, 32'h3);
		apb(1'b0, ADDR_CONV, 32'h0);
		check(rd, 32'h0);
		settle();
		check({31'h0, irq}, 32'h1);
		apb(1'b0, ADDR_EVENT, 32'h0);
		check(rd, 32'h100);
		settle();
		check({31'h0, irq}, 32'h0);
	endtask

	// Timeout and bad string events pass only with their own field.
	task automatic t_field_gates();
		apb(1'b1, ADDR_IRQ_EN, 32'h10);
		pulse(EVT_TIMEOUT);
		check({31'h0, irq}, 32'h0);
		apb(1'b1, ADDR_IRQ_EN, 32'h30);
		settle();
		check({31'h0, irq}, 32'h1);
		apb(1'b0, ADDR_EVENT, 32'h0);
		check(rd, 32'h40000);
		apb(1'b1, ADDR_IRQ_EN, 32'h04);
		pulse(EVT_BADCFG);
		check({31'h0, irq}, 32'h0);
		apb(1'b1, ADDR_IRQ_EN, 32'h0c);
		settle();
		check({31'h0, irq}, 32'h1);
		apb(1'b0, ADDR_EVENT, 32'h0);
		check(rd, 32'h20000);
		settle();
		check({31'h0, irq}, 32'h0);
	endtask

	// An unmapped word answers with an error and reads zero.
	task automatic t_unmapped();
		apb(1'b1, 12'h004, 32'hffff);
		check({31'h0, err}, 32'h1);
		apb(1'b0, 12'h004, 32'h0);
		check(rd, 32'h0);
		check({31'h0, err}, 32'h1);
		apb(1'b0, ADDR_CONV, 32'h0);
		check({31'h0, err}, 32'h0);
	endtask

	// A reset in mid-run brings enables and flags back to reset values.
	task automatic t_rerun();
		apb(1'b1, ADDR_IRQ_EN, 32'h55);
		pulse(SUP_SYNC);
		@(posedge clock);
		nrst <= 1'b0;
		repeat (3) @(posedge clock);
		nrst <= 1'b1;
		repeat (3) @(posedge clock);
		check({31'h0, irq}, 32'h0);
		apb(1'b0, ADDR_IRQ_EN, 32'h0);
		check(rd, 32'h000000aa);
		apb(1'b0, ADDR_SUPPLY, 32'h0);
		check(rd, 32'h0);
	endtask

	// Free-running clock of 10 ns.
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// Main sequence; reset is held for twelve cycles.
	initial begin
		nrst = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		det = '0;
		num_errors = 0;
		n_compared = 0;
		repeat (12) @(posedge clock);
		nrst <= 1'b1;
		repeat (3) @(posedge clock);
		t_reset();
		t_codes();
		t_faults();
		t_irq();
		t_field_gates();
		t_unmapped();
		t_rerun();
		print_verdict();
	end
endmodule

`default_nettype wire
